// >>> logic/cfg_header_pkg.sv
package cfg_header_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_ID = 8'h00;
   localparam logic [7:0] OFF_CMD_STAT = 8'h04;
   localparam logic [7:0] OFF_CLASS = 8'h08;
   localparam logic [7:0] OFF_LATENCY = 8'h0C;
   localparam logic [7:0] OFF_IO_BASE = 8'h10;
   localparam logic [7:0] OFF_MEM_BASE = 8'h14;
   localparam logic [7:0] OFF_CARD_INFO = 8'h28;
   localparam logic [7:0] OFF_SUBSYS = 8'h2C;
   localparam logic [7:0] OFF_BOOT_ROM = 8'h30;
   localparam logic [7:0] OFF_CAP_PTR = 8'h34;
   localparam logic [7:0] OFF_INTR = 8'h3C;
   localparam logic [7:0] OFF_DRIVER = 8'h40;
   localparam logic [7:0] OFF_SIGNATURE = 8'h80;
   localparam logic [7:0] OFF_PM_CAP = 8'hC0;
   localparam logic [7:0] OFF_PM_CTRL = 8'hC4;
   // Status bit positions (upper half of command/status)
   localparam int B_PE = 31;
   localparam int B_SE = 30;
   localparam int B_MA = 29;
   localparam int B_TA = 28;
   localparam int B_DPR = 24;
   localparam int B_B2B = 23;
   localparam int B_CAP = 20;
   // Command bit positions
   localparam int B_CSE = 8;
   localparam int B_CPE = 6;
   localparam int B_BME = 2;
   localparam int B_MSE = 1;
   localparam int B_ISE = 0;
   // Select timing field
   localparam int B_SEL_LO = 25;
   localparam logic [1:0] SEL_MEDIUM = 2'h1;
   // Value of command/status out of reset
   localparam logic [31:0] CMD_STAT_RESET = 32'h02900000;
   // Class code upper half: network controller, Ethernet
   localparam logic [7:0] BASE_CLASS = 8'h02;
   localparam logic [7:0] SUB_CLASS = 8'h00;
   // Fixed values
   localparam logic [7:0] CAP_PTR_VALUE = 8'hC0;
   localparam logic [7:0] INTR_PIN_VALUE = 8'h01;
   localparam logic [7:0] PM_NEXT_PTR = 8'h00;
   localparam logic [7:0] PM_CAP_ID = 8'h01;
   localparam logic [15:0] PM_CAPS = 16'h0000;
   // Writable field masks and the I/O space indicator bit
   localparam logic [31:0] IO_BASE_MASK = 32'hFFFFFF00;
   localparam logic [31:0] IO_SPACE_IND = 32'h00000001;
   localparam logic [31:0] MEM_BASE_MASK = 32'hFFFFFC00;
   localparam logic [31:0] BOOT_ROM_MASK = 32'hFFFE0001;
endpackage

// >>> logic/cardbus_config_header.sv
`timescale 1ns/10ps
module cardbus_config_header #(
   parameter logic [3:0] REVISION = 4'h0,
   parameter logic [3:0] STEP = 4'h0,
   // Arbitrary value
   parameter logic [31:0] SIGNATURE = 32'h12345678
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic [15:0] ee_device_ident,
   input wire logic [15:0] ee_vendor_ident,
   input wire logic [31:0] ee_card_info,
   input wire logic [31:0] ee_subsystem,
   input wire logic [7:0] ee_max_lat,
   input wire logic [7:0] ee_min_gnt,
   input wire logic parity_err,
   input wire logic addr_parity_err,
   input wire logic perr_event,
   input wire logic acting_master,
   input wire logic master_abort,
   input wire logic target_abort,
   input wire logic master_req,
   input wire logic mem_hit,
   input wire logic io_hit,
   input wire logic frame_active,
   input wire logic gnt_active,
   output logic serr_drive,
   output logic host_sys_error,
   output logic master_start,
   output logic mem_claim,
   output logic io_claim,
   output logic boot_rom_en,
   output logic tenure_end,
   output logic bus_master_en,
   output logic memory_space_en,
   output logic io_space_en
);
   typedef struct packed {
      logic load_pending;
      logic [15:0] dev_id;
      logic [15:0] ven_id;
      logic [31:0] card_info;
      logic [31:0] subsys;
      logic [7:0] max_lat;
      logic [7:0] min_gnt;
      logic pe;
      logic se;
      logic ma;
      logic ta;
      logic dpr;
      logic system_error_response_en;
      logic parity_response_en;
      logic bme;
      logic mse;
      logic ise;
      logic [7:0] limit;
      logic [7:0] cls;
      logic [31:0] io_base;
      logic [31:0] mem_base;
      logic [31:0] boot_rom;
      logic [7:0] intr_line;
      logic [7:0] scratch;
      logic [31:0] rdata;
      logic serr;
      logic host_se;
      logic m_start;
      logic m_claim;
      logic i_claim;
      logic rom_en;
      logic [7:0] tenure_cnt;
      logic frame_q;
      logic t_end;
   } state_t;

   state_t s;
   state_t next_s;

   function automatic logic sticky(input logic old, input logic set,
                                   input logic clr);
      // Set wins over a clear in the same cycle
      sticky = set | (old & ~clr);
   endfunction

   function automatic logic [31:0] mask_write(input logic [31:0] old,
                                              input logic [31:0] d,
                                              input logic [31:0] m);
      mask_write = (old & ~m) | (d & m);
   endfunction

   logic [31:0] cmd_stat;
   logic [31:0] read_value;
   logic stat_wr;
   logic frame_start;
   logic limit_expired;

   always_comb begin
      cmd_stat = '0;
      cmd_stat[cfg_header_pkg::B_PE] = s.pe;
      cmd_stat[cfg_header_pkg::B_SE] = s.se;
      cmd_stat[cfg_header_pkg::B_MA] = s.ma;
      cmd_stat[cfg_header_pkg::B_TA] = s.ta;
      cmd_stat[cfg_header_pkg::B_DPR] = s.dpr;
      cmd_stat[cfg_header_pkg::B_SEL_LO +: 2] = cfg_header_pkg::SEL_MEDIUM;
      cmd_stat[cfg_header_pkg::B_B2B] = 1'b1;
      cmd_stat[cfg_header_pkg::B_CAP] = 1'b1;
      cmd_stat[cfg_header_pkg::B_CSE] = s.system_error_response_en;
      cmd_stat[cfg_header_pkg::B_CPE] = s.parity_response_en;
      cmd_stat[cfg_header_pkg::B_BME] = s.bme;
      cmd_stat[cfg_header_pkg::B_MSE] = s.mse;
      cmd_stat[cfg_header_pkg::B_ISE] = s.ise;
   end

   always_comb begin
      read_value = '0;
      unique case (addr)
         cfg_header_pkg::OFF_ID: read_value = {s.dev_id, s.ven_id};
         cfg_header_pkg::OFF_CMD_STAT: read_value = cmd_stat;
         cfg_header_pkg::OFF_CLASS: read_value = {cfg_header_pkg::BASE_CLASS,
            cfg_header_pkg::SUB_CLASS, 8'h00, REVISION, STEP};
         cfg_header_pkg::OFF_LATENCY: read_value = {16'h0000, s.limit, s.cls};
         cfg_header_pkg::OFF_IO_BASE:
            read_value = s.io_base | cfg_header_pkg::IO_SPACE_IND;
         cfg_header_pkg::OFF_MEM_BASE: read_value = s.mem_base;
         cfg_header_pkg::OFF_CARD_INFO: read_value = s.card_info;
         cfg_header_pkg::OFF_SUBSYS: read_value = s.subsys;
         cfg_header_pkg::OFF_BOOT_ROM: read_value = s.boot_rom;
         cfg_header_pkg::OFF_CAP_PTR:
            read_value = {24'h000000, cfg_header_pkg::CAP_PTR_VALUE};
         cfg_header_pkg::OFF_INTR: read_value = {s.max_lat, s.min_gnt,
            cfg_header_pkg::INTR_PIN_VALUE, s.intr_line};
         cfg_header_pkg::OFF_DRIVER: read_value = {16'h0000, s.scratch, 8'h00};
         cfg_header_pkg::OFF_SIGNATURE: read_value = SIGNATURE;
         cfg_header_pkg::OFF_PM_CAP: read_value = {cfg_header_pkg::PM_CAPS,
            cfg_header_pkg::PM_NEXT_PTR, cfg_header_pkg::PM_CAP_ID};
         default: read_value = '0;
      endcase
   end

   assign stat_wr = wr && (addr == cfg_header_pkg::OFF_CMD_STAT);
   assign frame_start = frame_active && !s.frame_q;
   assign limit_expired = frame_active && !frame_start
                          && (s.tenure_cnt == 8'h00);

   always_comb begin
      next_s = s;
      next_s.rdata = rd ? read_value : '0;
      // Capture loaded fields right after reset release
      if (s.load_pending) begin
         next_s.load_pending = 1'b0;
         next_s.dev_id = ee_device_ident;
         next_s.ven_id = ee_vendor_ident;
         next_s.card_info = ee_card_info;
         next_s.subsys = ee_subsystem;
         next_s.max_lat = ee_max_lat;
         next_s.min_gnt = ee_min_gnt;
      end
      next_s.serr = s.system_error_response_en && addr_parity_err;
      next_s.host_se = s.parity_response_en && parity_err;
      next_s.pe = sticky(s.pe, parity_err,
                         stat_wr && wdata[cfg_header_pkg::B_PE]);
      next_s.se = sticky(s.se, s.serr,
                         stat_wr && wdata[cfg_header_pkg::B_SE]);
      next_s.ma = sticky(s.ma, master_abort && acting_master,
                         stat_wr && wdata[cfg_header_pkg::B_MA]);
      next_s.ta = sticky(s.ta, target_abort && acting_master,
                         stat_wr && wdata[cfg_header_pkg::B_TA]);
      next_s.dpr = sticky(s.dpr, perr_event && acting_master && s.parity_response_en,
                          stat_wr && wdata[cfg_header_pkg::B_DPR]);
      if (stat_wr) begin
         next_s.system_error_response_en = wdata[cfg_header_pkg::B_CSE];
         next_s.parity_response_en = wdata[cfg_header_pkg::B_CPE];
         next_s.bme = wdata[cfg_header_pkg::B_BME];
         next_s.mse = wdata[cfg_header_pkg::B_MSE];
         next_s.ise = wdata[cfg_header_pkg::B_ISE];
      end
      if (wr) begin
         unique case (addr)
            cfg_header_pkg::OFF_LATENCY: begin
               next_s.limit = wdata[15:8];
               next_s.cls = wdata[7:0];
            end
            cfg_header_pkg::OFF_IO_BASE: next_s.io_base = mask_write(
               s.io_base, wdata, cfg_header_pkg::IO_BASE_MASK);
            cfg_header_pkg::OFF_MEM_BASE: next_s.mem_base = mask_write(
               s.mem_base, wdata, cfg_header_pkg::MEM_BASE_MASK);
            cfg_header_pkg::OFF_BOOT_ROM: next_s.boot_rom = mask_write(
               s.boot_rom, wdata, cfg_header_pkg::BOOT_ROM_MASK);
            cfg_header_pkg::OFF_INTR: next_s.intr_line = wdata[7:0];
            cfg_header_pkg::OFF_DRIVER: next_s.scratch = wdata[15:8];
            default: next_s.scratch = s.scratch;
         endcase
      end
      next_s.m_start = master_req && s.bme;
      next_s.m_claim = mem_hit && s.mse;
      next_s.i_claim = io_hit && s.ise;
      next_s.rom_en = s.mse && s.boot_rom[0];
      next_s.frame_q = frame_active;
      if (frame_start) begin
         next_s.tenure_cnt = s.limit;
      end else if (frame_active && s.tenure_cnt != 8'h00) begin
         next_s.tenure_cnt = s.tenure_cnt - 8'h01;
      end
      next_s.t_end = limit_expired && !gnt_active;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s <= '0;
         s.load_pending <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign rdata = s.rdata;
   assign serr_drive = s.serr;
   assign host_sys_error = s.host_se;
   assign master_start = s.m_start;
   assign mem_claim = s.m_claim;
   assign io_claim = s.i_claim;
   assign boot_rom_en = s.rom_en;
   assign tenure_end = s.t_end;
   assign bus_master_en = s.bme;
   assign memory_space_en = s.mse;
   assign io_space_en = s.ise;

   id_reload_a: assert property (
      @(posedge clk) disable iff (reset)
      $past(reset) ##1 1'b1 |-> s.dev_id == $past(ee_device_ident))
      else $error("Identifier not reloaded after reset");

   id_read_a: assert property (
      @(posedge clk) disable iff (reset)
      rd && addr == cfg_header_pkg::OFF_ID
      |=> rdata == $past({s.dev_id, s.ven_id}))
      else $error("Identifier read wrong");

   cmd_reset_a: assert property (
      @(posedge clk) $past(reset) && !reset
      |-> cmd_stat == cfg_header_pkg::CMD_STAT_RESET)
      else $error("Command/status reset value wrong");

   pe_set_a: assert property (
      @(posedge clk) disable iff (reset)
      parity_err |=> s.pe)
      else $error("Parity status not set");

   se_follow_a: assert property (
      @(posedge clk) disable iff (reset)
      serr_drive |=> s.se)
      else $error("System error status not set");

   serr_cause_a: assert property (
      @(posedge clk) disable iff (reset)
      serr_drive |-> $past(addr_parity_err) && $past(s.system_error_response_en))
      else $error("System error without cause");

   dpr_cond_a: assert property (
      @(posedge clk) disable iff (reset)
      $rose(s.dpr) |-> $past(perr_event && acting_master && s.parity_response_en))
      else $error("Data parity bit set without conditions");

   w1c_clear_a: assert property (
      @(posedge clk) disable iff (reset)
      stat_wr && wdata[cfg_header_pkg::B_MA] && !master_abort
      |=> !s.ma)
      else $error("Status bit not cleared by one");

   master_gate_a: assert property (
      @(posedge clk) disable iff (reset)
      master_start |-> $past(s.bme))
      else $error("Master start while disabled");

   claim_gate_a: assert property (
      @(posedge clk) disable iff (reset)
      (mem_claim |-> $past(s.mse)) and (io_claim |-> $past(s.ise)))
      else $error("Target claim while disabled");

   rd_unmapped_a: assert property (
      @(posedge clk) disable iff (reset)
      rd && addr == 8'h18 |=> rdata == '0)
      else $error("Unmapped read not zero");

   tenure_a: assert property (
      @(posedge clk) disable iff (reset)
      tenure_end |-> $past(frame_active) && !$past(gnt_active))
      else $error("Tenure end without frame or with grant");

   const_bits_a: assert property (
      @(posedge clk) disable iff (reset)
      rd && addr == cfg_header_pkg::OFF_CMD_STAT
      |=> rdata[26:25] == cfg_header_pkg::SEL_MEDIUM && rdata[23]
          && rdata[20])
      else $error("Constant status bits wrong");

   ma_set_a: assert property (
      @(posedge clk) disable iff (reset)
      master_abort && acting_master |=> s.ma)
      else $error("Master abort status not set");

   ta_set_a: assert property (
      @(posedge clk) disable iff (reset)
      target_abort && acting_master |=> s.ta)
      else $error("Target abort status not set");

   host_se_a: assert property (
      @(posedge clk) disable iff (reset)
      parity_err && s.parity_response_en |=> host_sys_error)
      else $error("Host system error flag not raised");

   card_info_ro_a: assert property (
      @(posedge clk) disable iff (reset)
      wr && addr == cfg_header_pkg::OFF_CARD_INFO && !s.load_pending
      |=> s.card_info == $past(s.card_info))
      else $error("Card info pointer changed by write");

   scratch_rw_a: assert property (
      @(posedge clk) disable iff (reset)
      wr && addr == cfg_header_pkg::OFF_DRIVER
      |=> s.scratch == $past(wdata[15:8]))
      else $error("Scratch byte not stored");
endmodule

// >>> test/far_side_model.sv
`timescale 1ns/10ps
module far_side_model #(
   parameter logic [111:0] IMG_A = 112'h0,
   parameter logic [111:0] IMG_B = 112'h0
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic alt_image,
   output logic [15:0] ee_device_ident,
   output logic [15:0] ee_vendor_ident,
   output logic [31:0] ee_card_info,
   output logic [31:0] ee_subsystem,
   output logic [7:0] ee_max_lat,
   output logic [7:0] ee_min_gnt
);
   logic [111:0] image;
   logic settled;
   // Image offered at release, then scrambled
   always_ff @(posedge clk) begin
      if (reset) begin
         image <= alt_image ? IMG_B : IMG_A;
         settled <= 1'b0;
      end else begin
         settled <= 1'b1;
         if (settled) begin
            image <= ~image;
         end
      end
   end
   assign ee_device_ident = image[111:96];
   assign ee_vendor_ident = image[95:80];
   assign ee_card_info = image[79:48];
   assign ee_subsystem = image[47:16];
   assign ee_max_lat = image[15:8];
   assign ee_min_gnt = image[7:0];
endmodule

// >>> test/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   localparam logic [111:0] IMG_A = 112'h1357_2468_00001A07_5A5AC3C3_40_10;
   localparam logic [111:0] IMG_B = 112'hBEEF_0F0F_80000017_12348765_22_11;
   // Arbitrary value
   localparam logic [31:0] SIG = 32'h0BADF00D;
   localparam logic [31:0] CLASS_EXP = 32'h020000A5;
   localparam logic [7:0] RO_ADDR [6] = '{8'h28, 8'h80, 8'h40, 8'h18, 8'h08,
      8'h00};
   localparam logic [31:0] RO_EXP [6] = '{IMG_A[79:48], SIG, 32'h0000FF00,
      32'h0, CLASS_EXP, IMG_A[111:80]};
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic alt_image = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [4:0] ev = 5'h0;
   logic [2:0] req = 3'h0;
   logic acting_master = 1'b0;
   logic frame_active = 1'b0;
   logic gnt_active = 1'b0;
   logic [31:0] rdata;
   logic [15:0] ee_device_ident, ee_vendor_ident;
   logic [31:0] ee_card_info, ee_subsystem;
   logic [7:0] ee_max_lat, ee_min_gnt;
   logic serr_drive, host_sys_error, master_start, mem_claim, io_claim;
   logic boot_rom_en, tenure_end, bus_master_en, memory_space_en, io_space_en;
   int miscompares = 0;
   int checks = 0;
   int cycles = 0;
   int n;

   always #2 clk = ~clk;

   far_side_model #(.IMG_A(IMG_A), .IMG_B(IMG_B)) far_u (.clk(clk),
      .reset(reset), .alt_image(alt_image), .ee_device_ident(ee_device_ident),
      .ee_vendor_ident(ee_vendor_ident), .ee_card_info(ee_card_info),
      .ee_subsystem(ee_subsystem), .ee_max_lat(ee_max_lat),
      .ee_min_gnt(ee_min_gnt));

   cardbus_config_header #(.REVISION(4'hA), .STEP(4'h5), .SIGNATURE(SIG))
   dut_u (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .ee_device_ident(ee_device_ident),
      .ee_vendor_ident(ee_vendor_ident), .ee_card_info(ee_card_info),
      .ee_subsystem(ee_subsystem), .ee_max_lat(ee_max_lat),
      .ee_min_gnt(ee_min_gnt), .parity_err(ev[0]), .addr_parity_err(ev[1]),
      .perr_event(ev[2]), .acting_master(acting_master),
      .master_abort(ev[3]), .target_abort(ev[4]), .master_req(req[2]),
      .mem_hit(req[1]), .io_hit(req[0]), .frame_active(frame_active),
      .gnt_active(gnt_active), .serr_drive(serr_drive),
      .host_sys_error(host_sys_error), .master_start(master_start),
      .mem_claim(mem_claim), .io_claim(io_claim), .boot_rom_en(boot_rom_en),
      .tenure_end(tenure_end), .bus_master_en(bus_master_en),
      .memory_space_en(memory_space_en), .io_space_en(io_space_en));

   task automatic tally_and_finish;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen,
                        input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask

   task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic read_check(input string name, input logic [7:0] a,
                             input logic [31:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      check(name, rdata, exp);
   endtask

   task automatic do_reset(input logic img);
      @(posedge clk);
      alt_image <= img;
      reset <= 1'b1;
      repeat (16) @(posedge clk);
      reset <= 1'b0;
   endtask

   task automatic pulse(input logic [4:0] e);
      @(posedge clk);
      ev <= e;
      @(posedge clk);
      ev <= 5'h0;
      #1;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         tally_and_finish();
      end
   end

   initial begin
      do_reset(1'b0);
      read_check("device_vendor", 8'h00, IMG_A[111:80]);
      read_check("card_info", 8'h28, IMG_A[79:48]);
      read_check("cmd_status", 8'h04, 32'h02900000);
      check("enables", {29'h0, bus_master_en, memory_space_en, io_space_en},
         32'h0);
      read_check("class", 8'h08, CLASS_EXP);
      @(posedge clk);
      #1;
      check("rdata_idle", rdata, 32'h0);
      for (int k = 0; k < 6; k++) begin
         write_reg(RO_ADDR[k], 32'hFFFFFFFF);
         read_check("after_write", RO_ADDR[k],
            RO_EXP[k]);
      end
      for (int k = 0; k < 2; k++) begin
         write_reg(8'h04, k ? 32'h00000147 : 32'h0);
         @(posedge clk);
         req <= 3'h7;
         @(posedge clk);
         req <= 3'h0;
         #1;
         check("claims", {29'h0, master_start, mem_claim, io_claim},
            k ? 32'h7 : 32'h0);
         check("enables", {29'h0, bus_master_en, memory_space_en,
            io_space_en}, k ? 32'h7 : 32'h0);
      end
      read_check("cmd_status", 8'h04, 32'h02900147);
      write_reg(8'h30, 32'hFFFFFFFF);
      read_check("boot_rom", 8'h30, 32'hFFFE0001);
      check("boot_rom_en", {31'h0, boot_rom_en}, 32'h1);
      @(posedge clk);
      acting_master <= 1'b1;
      pulse(5'b00011);
      check("sys_err_out", {30'h0, serr_drive, host_sys_error},
         32'h3);
      read_check("cmd_status", 8'h04, 32'hC2900147);
      pulse(5'b11100);
      read_check("cmd_status", 8'h04,
         32'hF3900147);
      write_reg(8'h04, 32'hC0000147);
      read_check("cmd_status", 8'h04, 32'h33900147);
      write_reg(8'h04, 32'hF1000147);
      read_check("cmd_status", 8'h04, 32'h02900147);
      write_reg(8'h04, 32'h00000107);
      pulse(5'b00101);
      check("sys_err_out", {30'h0, serr_drive, host_sys_error},
         32'h0);
      read_check("cmd_status", 8'h04, 32'h82900107);
      write_reg(8'h0C, 32'h00000300);
      @(posedge clk);
      frame_active <= 1'b1;
      gnt_active <= 1'b1;
      repeat (2) @(posedge clk);
      gnt_active <= 1'b0;
      n = 0;
      while (tenure_end !== 1'b1 && n < 12) begin
         @(posedge clk);
         #1;
         n++;
      end
      check("tenure_end", {31'h0, tenure_end}, 32'h1);
      check("tenure_cycles", n, 32'h3);
      @(posedge clk);
      frame_active <= 1'b0;
      acting_master <= 1'b0;
      do_reset(1'b1);
      read_check("device_vendor", 8'h00, IMG_B[111:80]);
      read_check("subsystem", 8'h2C, IMG_B[47:16]);
      read_check("intr", 8'h3C, {IMG_B[15:0], 16'h0100});
      read_check("cmd_status", 8'h04, 32'h02900000);
      tally_and_finish();
   end
endmodule
